// ### hdl/frs_pkg.sv
package frs_pkg;

    localparam logic [7:0] FEATURE_ADDR = 8'h66;
    localparam logic FEATURE_PRESENT = 1'b1;

    localparam int CLK_PERIOD_NS = 100;
    // service window for one pending dma byte; a longest time, so it rounds down
    localparam int OVR_TIME_NS = 13000;
    localparam int OVR_CYCLES_RAW = OVR_TIME_NS / CLK_PERIOD_NS;
    localparam int OVR_CYCLES = (OVR_CYCLES_RAW < 1) ? 1 : OVR_CYCLES_RAW;
    localparam logic [7:0] OVR_LAST = 8'(OVR_CYCLES - 1);

    localparam logic [6:0] MAX_STEPS = 7'h4d;
    localparam logic [1:0] INDEX_LIMIT = 2'h2;
    localparam logic [7:0] CYL_ALL_ONES = 8'hff;
    localparam logic [1:0] LAST_RESULT = 2'h3;

    localparam logic [1:0] TC_NORMAL = 2'h0;
    localparam logic [1:0] TC_ABNORMAL = 2'h1;
    localparam logic [1:0] TC_INVALID = 2'h2;

    localparam int S0_TC_LO = 6;
    localparam int S0_SEEK_END = 5;
    localparam int S0_EQUIP = 4;
    localparam int S0_NOT_READY = 3;
    localparam int S0_HEAD = 2;
    localparam int S0_UNIT_LO = 0;
    localparam int S1_END_CYL = 7;
    localparam int S1_CRC_ANY = 5;
    localparam int S1_OVERRUN = 4;
    localparam int S1_NO_DATA = 2;
    localparam int S1_NOT_WR = 1;
    localparam int S1_MISS_MARK = 0;
    localparam int S2_CTRL_MARK = 6;
    localparam int S2_CRC_DATA = 5;
    localparam int S2_WRONG_CYL = 4;
    localparam int S2_SCAN_EQ = 3;
    localparam int S2_SCAN_NOT = 2;
    localparam int S2_BAD_CYL = 1;
    localparam int S2_MISS_DATA = 0;
    localparam int S3_WP_HI = 6;
    localparam int S3_READY = 5;
    localparam int S3_TRACK0 = 4;
    localparam int S3_WP_LO = 3;
    localparam int S3_HEAD = 2;
    localparam int S3_UNIT_LO = 0;

    localparam logic [7:0] S0_RESET = 8'h00;
    localparam logic [7:0] S1_RESET = 8'h00;
    localparam logic [7:0] S2_RESET = 8'h00;
    localparam logic [7:0] S3_RESET = 8'h68;
    localparam logic [7:0] MSB_RESET = 8'h00;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT,
        CMD_SCAN, CMD_SEEK, CMD_RECAL, CMD_READ_ID, CMD_READ_TRACK
    } frs_cmd_t;

    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_RESULT} frs_phase_t;

    function automatic logic cmd_is_write(input frs_cmd_t c);
        return (c == CMD_WRITE) || (c == CMD_WRITE_DEL) || (c == CMD_FORMAT);
    endfunction

    function automatic logic cmd_is_rw(input frs_cmd_t c);
        return cmd_is_write(c) || (c == CMD_READ) || (c == CMD_SCAN) ||
               (c == CMD_READ_ID) || (c == CMD_READ_TRACK);
    endfunction

endpackage

// ### hdl/frs_overrun_watch.sv
`timescale 1ns/1ns
`default_nettype none
module frs_overrun_watch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic active,
    input wire logic dma_pending,
    input wire logic dma_ack,
    output logic overrun
);
    logic [7:0] wait_count;
    logic fired;

    // one flag per pending byte: a late host is reported once, not every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_count <= 8'h00;
            fired <= 1'b0;
            overrun <= 1'b0;
        end else begin
            overrun <= 1'b0;
            if (!active || !dma_pending || dma_ack) begin
                wait_count <= 8'h00;
                fired <= 1'b0;
            end else if (wait_count == frs_pkg::OVR_LAST) begin
                overrun <= !fired; // [R2]
                fired <= 1'b1;
            end else begin
                wait_count <= wait_count + 8'h01;
            end
        end
    end

    chk_overrun_late: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        overrun |-> $past(active) && $past(dma_pending) && !$past(dma_ack) && !$past(fired))
        else $error("overrun flagged without a late pending dma byte");

endmodule
`default_nettype wire

// ### hdl/frs_result_status.sv
// Overview of operation
// R1: seeking drive refuses read or write commands
// R2: late dma service sets overrun flag
// R3: feature location reads overrun support bit
// R4: four result bytes, after execution, read in order
// R5: termination code: normal, abnormal, invalid
// R6: seek end set on completed seek
// R7: no track zero after 77 steps: equipment check
// R8: not ready bit always zero
// R9: head and unit captured at interrupt
// R10: end of cylinder on overrun past last sector
// R11: unused result bits always read zero
// R12: any crc error sets data error
// R13: data field crc sets data field bit
// R14: sector, id or start not found: no data; code sets it only for read types and write deleted
// R15: write protect during write commands: not writable
// R16: missing address marks set mark bits
// R17: deleted mark in read or scan: control mark
// R18: cylinder mismatch wrong, all ones bad
// R19: scan equal and scan not satisfied bits
// R20: ready bit always one
// R21: track zero bit follows drive input
// R22: two bits mirror active low write protect
// R23: head and unit bits follow drive outputs
`timescale 1ns/1ns
`default_nettype none
module frs_result_status (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_rd,
    input wire logic host_a0,
    input wire logic ram_rd,
    input wire logic [7:0] ram_addr,
    output logic [7:0] rd_data,
    output logic [7:0] main_status_byte,
    output logic results_ready,
    input wire logic [3:0] seek_start,
    input wire logic [3:0] seek_done,
    input wire logic cmd_req,
    input wire frs_pkg::frs_cmd_t cmd_class,
    input wire logic [1:0] cmd_unit,
    output logic cmd_refused,
    output logic cmd_accepted,
    input wire logic exec_start,
    input wire logic exec_done,
    input wire logic exec_invalid,
    input wire logic evt_end_cyl,
    input wire logic evt_crc_id,
    input wire logic evt_crc_data,
    input wire logic evt_no_data,
    input wire logic evt_data_mark_missing,
    input wire logic evt_deleted_mark,
    input wire logic id_search,
    input wire logic index_pulse,
    input wire logic id_mark_found,
    input wire logic cyl_check,
    input wire logic [7:0] medium_cyl,
    input wire logic [7:0] stored_cyl,
    input wire logic scan_equal,
    input wire logic scan_unmet,
    input wire logic step_pulse,
    input wire logic dma_pending,
    input wire logic dma_ack,
    input wire logic track_zero,
    input wire logic write_protect_n,
    input wire logic side_select,
    input wire logic [1:0] unit_select
);
    frs_pkg::frs_phase_t phase;
    frs_pkg::frs_cmd_t active_cmd;
    logic [7:0] result_status_zero;
    logic [7:0] result_status_one;
    logic [7:0] result_status_two;
    logic [7:0] result_status_three;
    logic [1:0] result_index;
    logic [1:0] index_count;
    logic [6:0] step_count;
    logic track_zero_seen;
    logic overrun_pulse;
    logic in_exec;
    logic result_read;
    logic any_error;
    logic equip_fail;
    logic [1:0] next_code;
    logic [7:0] result_byte;

    assign in_exec = (phase == frs_pkg::PH_EXEC) && !exec_start;
    assign result_read = host_rd && host_a0 && (phase == frs_pkg::PH_RESULT);
    assign equip_fail = (active_cmd == frs_pkg::CMD_RECAL) &&
                        (step_count >= frs_pkg::MAX_STEPS) && !track_zero_seen; // [R7]
    assign any_error = (result_status_one != 8'h00) ||
                       (result_status_two[frs_pkg::S2_CTRL_MARK:frs_pkg::S2_WRONG_CYL] != 3'h0) ||
                       result_status_two[frs_pkg::S2_SCAN_NOT] || result_status_two[frs_pkg::S2_BAD_CYL] ||
                       result_status_two[frs_pkg::S2_MISS_DATA] || equip_fail;
    assign next_code = exec_invalid ? frs_pkg::TC_INVALID :
                       (any_error ? frs_pkg::TC_ABNORMAL : frs_pkg::TC_NORMAL); // [R5]

    frs_overrun_watch u_overrun (
        .clk(clk),
        .rst_n(rst_n),
        .active(in_exec),
        .dma_pending(dma_pending),
        .dma_ack(dma_ack),
        .overrun(overrun_pulse)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_status_byte <= frs_pkg::MSB_RESET;
        end else begin
            // a start in the same cycle as a done keeps the drive busy
            main_status_byte[3:0] <= (main_status_byte[3:0] & ~seek_done) | seek_start; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_refused <= 1'b0;
            cmd_accepted <= 1'b0;
        end else begin
            cmd_refused <= cmd_req && frs_pkg::cmd_is_rw(cmd_class) && main_status_byte[cmd_unit]; // [R1]
            cmd_accepted <= cmd_req && !(frs_pkg::cmd_is_rw(cmd_class) && main_status_byte[cmd_unit]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= frs_pkg::PH_IDLE;
            results_ready <= 1'b0;
            result_index <= 2'h0;
            active_cmd <= frs_pkg::CMD_NONE;
        end else begin
            case (phase)
                frs_pkg::PH_EXEC: begin
                    if (exec_done) begin
                        phase <= frs_pkg::PH_RESULT; // [R4]
                        results_ready <= 1'b1;
                        result_index <= 2'h0;
                    end
                end
                frs_pkg::PH_RESULT: begin
                    if (exec_start) begin
                        phase <= frs_pkg::PH_EXEC;
                        results_ready <= 1'b0;
                        active_cmd <= cmd_class;
                    end else if (result_read) begin
                        result_index <= result_index + 2'h1; // [R4]
                        if (result_index == frs_pkg::LAST_RESULT) begin
                            phase <= frs_pkg::PH_IDLE;
                            results_ready <= 1'b0;
                        end
                    end
                end
                default: begin
                    if (exec_start) begin
                        phase <= frs_pkg::PH_EXEC;
                        active_cmd <= cmd_class;
                    end
                end
            endcase
        end
    end

    // recalibrate step and index pulse tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_count <= 7'h00;
            track_zero_seen <= 1'b0;
            index_count <= 2'h0;
        end else if (exec_start) begin
            step_count <= 7'h00;
            track_zero_seen <= 1'b0;
            index_count <= 2'h0;
        end else if (phase == frs_pkg::PH_EXEC) begin
            if (step_pulse && step_count < frs_pkg::MAX_STEPS) begin
                step_count <= step_count + 7'h01; // [R7]
            end
            if (track_zero) begin
                track_zero_seen <= 1'b1;
            end
            if (!id_search || id_mark_found) begin
                index_count <= 2'h0;
            end else if (index_pulse && index_count < frs_pkg::INDEX_LIMIT) begin
                index_count <= index_count + 2'h1; // [R16]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_status_zero <= frs_pkg::S0_RESET;
        end else if (phase == frs_pkg::PH_EXEC && exec_done && !exec_start) begin
            result_status_zero[frs_pkg::S0_TC_LO +: 2] <= next_code; // [R5]
            result_status_zero[frs_pkg::S0_SEEK_END] <= !exec_invalid &&
                ((active_cmd == frs_pkg::CMD_SEEK) || (active_cmd == frs_pkg::CMD_RECAL)); // [R6]
            result_status_zero[frs_pkg::S0_EQUIP] <= equip_fail; // [R7]
            result_status_zero[frs_pkg::S0_NOT_READY] <= 1'b0; // [R8]
            result_status_zero[frs_pkg::S0_HEAD] <= side_select; // [R9]
            result_status_zero[frs_pkg::S0_UNIT_LO +: 2] <= unit_select; // [R9]
        end
    end

    // error flags collect over the execution phase; only named bits are ever set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_status_one <= frs_pkg::S1_RESET;
        end else if (exec_start) begin
            result_status_one <= frs_pkg::S1_RESET;
        end else if (in_exec) begin
            if (evt_end_cyl) result_status_one[frs_pkg::S1_END_CYL] <= 1'b1; // [R10]
            if (evt_crc_id || evt_crc_data) result_status_one[frs_pkg::S1_CRC_ANY] <= 1'b1; // [R12]
            if (overrun_pulse) result_status_one[frs_pkg::S1_OVERRUN] <= 1'b1; // [R2]
            if (evt_no_data && frs_pkg::cmd_is_rw(active_cmd) && !frs_pkg::cmd_is_write(active_cmd) ||
                evt_no_data && active_cmd == frs_pkg::CMD_WRITE_DEL) begin
                result_status_one[frs_pkg::S1_NO_DATA] <= 1'b1; // [R14]
            end
            if (!write_protect_n && frs_pkg::cmd_is_write(active_cmd)) begin
                result_status_one[frs_pkg::S1_NOT_WR] <= 1'b1; // [R15]
            end
            if ((index_pulse && id_search && !id_mark_found && index_count == frs_pkg::INDEX_LIMIT - 2'h1) ||
                evt_data_mark_missing) begin
                result_status_one[frs_pkg::S1_MISS_MARK] <= 1'b1; // [R16]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_status_two <= frs_pkg::S2_RESET;
        end else if (exec_start) begin
            result_status_two <= frs_pkg::S2_RESET;
        end else if (in_exec) begin
            if (evt_deleted_mark && (active_cmd == frs_pkg::CMD_READ || active_cmd == frs_pkg::CMD_SCAN)) begin
                result_status_two[frs_pkg::S2_CTRL_MARK] <= 1'b1; // [R17]
            end
            if (evt_crc_data) result_status_two[frs_pkg::S2_CRC_DATA] <= 1'b1; // [R13]
            if (cyl_check && medium_cyl != stored_cyl) begin
                result_status_two[frs_pkg::S2_WRONG_CYL] <= 1'b1; // [R18]
                if (medium_cyl == frs_pkg::CYL_ALL_ONES) result_status_two[frs_pkg::S2_BAD_CYL] <= 1'b1; // [R18]
            end
            if (active_cmd == frs_pkg::CMD_SCAN) begin
                if (scan_equal) result_status_two[frs_pkg::S2_SCAN_EQ] <= 1'b1; // [R19]
                if (scan_unmet) result_status_two[frs_pkg::S2_SCAN_NOT] <= 1'b1; // [R19]
            end
            if (evt_data_mark_missing) result_status_two[frs_pkg::S2_MISS_DATA] <= 1'b1; // [R16]
        end
    end

    // drive lines are shown live; the bus sees them one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_status_three <= frs_pkg::S3_RESET;
        end else begin
            result_status_three <= 8'h00; // [R11]
            result_status_three[frs_pkg::S3_WP_HI] <= write_protect_n; // [R22]
            result_status_three[frs_pkg::S3_READY] <= 1'b1; // [R20]
            result_status_three[frs_pkg::S3_TRACK0] <= track_zero; // [R21]
            result_status_three[frs_pkg::S3_WP_LO] <= write_protect_n; // [R22]
            result_status_three[frs_pkg::S3_HEAD] <= side_select; // [R23]
            result_status_three[frs_pkg::S3_UNIT_LO +: 2] <= unit_select; // [R23]
        end
    end

    always_comb begin
        case (result_index)
            2'h0: result_byte = result_status_zero;
            2'h1: result_byte = result_status_one;
            2'h2: result_byte = result_status_two;
            default: result_byte = result_status_three;
        endcase
    end

    // result reads outside the result phase return zero and do not advance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (host_rd && !host_a0) begin
            rd_data <= main_status_byte;
        end else if (host_rd) begin
            rd_data <= result_read ? result_byte : 8'h00; // [R4]
        end else if (ram_rd) begin
            rd_data <= (ram_addr == frs_pkg::FEATURE_ADDR) ? {7'h00, frs_pkg::FEATURE_PRESENT} : 8'h00; // [R3]
        end
    end

    chk_seek_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        cmd_req && frs_pkg::cmd_is_rw(cmd_class) && main_status_byte[cmd_unit] |=> cmd_refused && !cmd_accepted)
        else $error("rw command to a seeking drive was not refused");
    chk_overrun_sets: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        in_exec && overrun_pulse |=> result_status_one[frs_pkg::S1_OVERRUN])
        else $error("overrun pulse did not set the overrun bit");
    chk_feature_read: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        ram_rd && !host_rd && ram_addr == frs_pkg::FEATURE_ADDR |=> rd_data == 8'h01)
        else $error("feature location read back wrong");
    chk_result_order: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        result_read && !exec_start && result_index == 2'h3 |=> phase == frs_pkg::PH_IDLE && !results_ready)
        else $error("fourth result read did not end the result phase");
    chk_invalid_code: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        phase == frs_pkg::PH_EXEC && exec_done && exec_invalid && !exec_start |=>
        result_status_zero[7:6] == 2'h2 && results_ready)
        else $error("invalid command did not report code 10");
    chk_equip_check: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        phase == frs_pkg::PH_EXEC && exec_done && !exec_start && active_cmd == frs_pkg::CMD_RECAL &&
        step_count == frs_pkg::MAX_STEPS && !track_zero_seen |=> result_status_zero[frs_pkg::S0_EQUIP])
        else $error("recalibrate failure not flagged");
    chk_unused_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        !result_status_one[6] && !result_status_one[3] && !result_status_two[7] &&
        !result_status_three[7] && !result_status_zero[frs_pkg::S0_NOT_READY])
        else $error("unused result bit reads one");
    chk_wrong_cyl: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        in_exec && cyl_check && medium_cyl != stored_cyl |=> result_status_two[frs_pkg::S2_WRONG_CYL] &&
        (result_status_two[frs_pkg::S2_BAD_CYL] == ($past(medium_cyl) == 8'hff) || $past(result_status_two[1])))
        else $error("cylinder mismatch not reported");
    chk_drive_lines: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        ##1 result_status_three[frs_pkg::S3_TRACK0] == $past(track_zero) &&
        result_status_three[frs_pkg::S3_WP_HI] == $past(write_protect_n) && result_status_three[frs_pkg::S3_READY])
        else $error("fourth result byte does not follow drive lines");

    chk_seek_accept: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        cmd_req && !(frs_pkg::cmd_is_rw(cmd_class) && main_status_byte[cmd_unit]) |=> cmd_accepted && !cmd_refused)
        else $error("command to an idle drive was not accepted");

    chk_busy_set: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        seek_start != 4'h0 |=> (main_status_byte[3:0] & $past(seek_start)) == $past(seek_start))
        else $error("seek start did not mark the drive busy");

    chk_head_capture: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        phase == frs_pkg::PH_EXEC && exec_done && !exec_start |=> result_status_zero[frs_pkg::S0_HEAD] ==
        $past(side_select) && result_status_zero[frs_pkg::S0_UNIT_LO +: 2] == $past(unit_select))
        else $error("head or unit not captured at the end of execution");

    chk_crc_any: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        in_exec && (evt_crc_id || evt_crc_data) |=> result_status_one[frs_pkg::S1_CRC_ANY])
        else $error("crc error did not set the data error bit");

    chk_mark_pair: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        in_exec && evt_data_mark_missing |=>
        result_status_one[frs_pkg::S1_MISS_MARK] && result_status_two[frs_pkg::S2_MISS_DATA])
        else $error("missing data mark not flagged in both registers");

    chk_write_prot: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        in_exec && !write_protect_n && frs_pkg::cmd_is_write(active_cmd) |=> result_status_one[frs_pkg::S1_NOT_WR])
        else $error("write to a protected disk not flagged");

endmodule
`default_nettype wire

// ### tb/frs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module frs_host_model (
    input wire logic clk,
    output logic host_rd,
    output logic host_a0,
    output logic ram_rd,
    output logic [7:0] ram_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        host_rd = 1'b0;
        host_a0 = 1'b0;
        ram_rd = 1'b0;
        ram_addr = 8'h00;
    end
    // one pulse per byte; callers fetch result bytes strictly in order 0..3
    task automatic rd(input logic ram, input logic a0, input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        host_rd <= !ram;
        host_a0 <= a0;
        ram_rd <= ram; // clock ram probe of the feature location
        ram_addr <= addr;
        @(posedge clk);
        host_rd <= 1'b0;
        ram_rd <= 1'b0;
        // released address lines do not keep their last value
        ram_addr <= ~addr;
        #1 data = rd_data;
    endtask
endmodule
`default_nettype wire

// ### tb/frs_result_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module frs_result_status_tb;
    logic clk = 1'b0, rst_n = 1'b0;
    logic host_rd, host_a0, ram_rd, results_ready, cmd_refused, cmd_accepted;
    logic [7:0] ram_addr, rd_data, main_status_byte;
    logic [3:0] seek_start = 4'h0, seek_done = 4'h0;
    logic cmd_req = 1'b0, exec_start = 1'b0, exec_done = 1'b0, exec_invalid = 1'b0, id_search = 1'b0;
    frs_pkg::frs_cmd_t cmd_class = frs_pkg::CMD_NONE;
    logic [1:0] cmd_unit = 2'h0, unit_select = 2'h0;
    logic [8:0] ev = 9'h000;
    logic [7:0] medium_cyl = 8'h00, stored_cyl = 8'h00;
    logic step_pulse = 1'b0, dma_pending = 1'b0, track_zero = 1'b0, write_protect_n = 1'b1, side_select = 1'b0;
    int error_cnt = 0, n_compared = 0, cyc = 0;

    always #50 clk = ~clk;

    frs_host_model frs_host_model_inst (.clk(clk), .host_rd(host_rd), .host_a0(host_a0), .ram_rd(ram_rd),
        .ram_addr(ram_addr), .rd_data(rd_data));

    frs_result_status frs_result_status_inst (.clk(clk), .rst_n(rst_n), .host_rd(host_rd), .host_a0(host_a0),
        .ram_rd(ram_rd), .ram_addr(ram_addr), .rd_data(rd_data), .main_status_byte(main_status_byte),
        .results_ready(results_ready), .seek_start(seek_start), .seek_done(seek_done), .cmd_req(cmd_req),
        .cmd_class(cmd_class), .cmd_unit(cmd_unit), .cmd_refused(cmd_refused), .cmd_accepted(cmd_accepted),
        .exec_start(exec_start), .exec_done(exec_done), .exec_invalid(exec_invalid), .evt_end_cyl(ev[8]),
        .evt_crc_id(ev[7]), .evt_crc_data(ev[6]), .evt_no_data(ev[5]), .evt_data_mark_missing(ev[4]),
        .evt_deleted_mark(ev[3]), .id_search(id_search), .index_pulse(step_pulse), .id_mark_found(1'b0),
        .cyl_check(ev[0]), .medium_cyl(medium_cyl), .stored_cyl(stored_cyl), .scan_equal(ev[2]),
        .scan_unmet(ev[1]), .step_pulse(step_pulse), .dma_pending(dma_pending), .dma_ack(1'b0),
        .track_zero(track_zero), .write_protect_n(write_protect_n), .side_select(side_select),
        .unit_select(unit_select));

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic drive_lines(input logic side, input logic [1:0] unit, input logic tz, input logic wp_n);
        @(posedge clk);
        side_select <= side;
        unit_select <= unit;
        cmd_unit <= unit;
        track_zero <= tz;
        write_protect_n <= wp_n;
    endtask

    task automatic offer(input frs_pkg::frs_cmd_t c, input logic [1:0] u, input logic refuse);
        @(posedge clk);
        cmd_req <= 1'b1;
        cmd_class <= c;
        cmd_unit <= u;
        @(posedge clk);
        cmd_req <= 1'b0;
        #1 chk({6'h00, cmd_refused, cmd_accepted}, {6'h00, refuse, !refuse});
    endtask

    task automatic exec(input frs_pkg::frs_cmd_t c, input logic inv, input logic [8:0] e, input int steps,
            input int dmac);
        @(posedge clk);
        cmd_class <= c;
        exec_start <= 1'b1;
        @(posedge clk);
        exec_start <= 1'b0;
        ev <= e;
        medium_cyl <= e[0] ? 8'hff : 8'h00;
        stored_cyl <= 8'h03;
        @(posedge clk);
        ev <= 9'h000;
        repeat (steps) begin
            @(posedge clk);
            step_pulse <= 1'b1;
            @(posedge clk);
            step_pulse <= 1'b0;
        end
        if (dmac > 0) begin
            @(posedge clk);
            dma_pending <= 1'b1;
            repeat (dmac) @(posedge clk);
            dma_pending <= 1'b0;
        end
        @(posedge clk);
        exec_done <= 1'b1;
        exec_invalid <= inv;
        @(posedge clk);
        exec_done <= 1'b0;
        exec_invalid <= 1'b0;
        @(posedge clk);
        #1 chk({7'h00, results_ready}, 8'h01);
    endtask

    // after the fourth byte the phase closes and a further result read gives zero
    task automatic results(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
        logic [7:0] d;
        logic [7:0] e [4];
        e = '{e0, e1, e2, e3};
        for (int i = 0; i < 4; i++) begin
            frs_host_model_inst.rd(1'b0, 1'b1, 8'h00, d);
            chk(d, e[i]);
        end
        chk({7'h00, results_ready}, 8'h00);
        frs_host_model_inst.rd(1'b0, 1'b1, 8'h00, d);
        chk(d, 8'h00);
    endtask

    task automatic test_feature_and_idle();
        logic [7:0] d;
        frs_host_model_inst.rd(1'b1, 1'b0, frs_pkg::FEATURE_ADDR, d);
        chk(d, 8'h01);
        frs_host_model_inst.rd(1'b1, 1'b0, 8'h65, d);
        chk(d, 8'h00);
        frs_host_model_inst.rd(1'b1, 1'b0, frs_pkg::FEATURE_ADDR, d);
        chk(d, 8'h01);
        frs_host_model_inst.rd(1'b0, 1'b1, 8'h00, d);
        chk(d, 8'h00);
    endtask

    task automatic test_seek_busy();
        logic [7:0] d;
        @(posedge clk);
        seek_start <= 4'h2;
        @(posedge clk);
        seek_start <= 4'h0;
        frs_host_model_inst.rd(1'b0, 1'b0, 8'h00, d);
        chk(d, 8'h02);
        offer(frs_pkg::CMD_READ, 2'h1, 1'b1);
        offer(frs_pkg::CMD_FORMAT, 2'h1, 1'b1);
        offer(frs_pkg::CMD_SEEK, 2'h1, 1'b0);
        offer(frs_pkg::CMD_WRITE, 2'h0, 1'b0);
        @(posedge clk);
        seek_done <= 4'h2;
        @(posedge clk);
        seek_done <= 4'h0;
        offer(frs_pkg::CMD_READ, 2'h1, 1'b0);
        chk(main_status_byte, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_feature_and_idle();
        test_seek_busy();
        drive_lines(1'b1, 2'h2, 1'b0, 1'b1);
        exec(frs_pkg::CMD_READ, 1'b0, 9'h148, 0, 0);
        results(8'h46, 8'ha0, 8'h60, 8'h6e);
        drive_lines(1'b0, 2'h1, 1'b1, 1'b0);
        exec(frs_pkg::CMD_WRITE, 1'b0, 9'h080, 0, 0);
        results(8'h41, 8'h22, 8'h00, 8'h31);
        drive_lines(1'b0, 2'h0, 1'b0, 1'b1);
        exec(frs_pkg::CMD_RECAL, 1'b0, 9'h000, 77, 0);
        results(8'h70, 8'h00, 8'h00, 8'h68);
        exec(frs_pkg::CMD_SEEK, 1'b0, 9'h000, 0, 0);
        results(8'h20, 8'h00, 8'h00, 8'h68);
        exec(frs_pkg::CMD_READ, 1'b1, 9'h000, 0, 0);
        results(8'h80, 8'h00, 8'h00, 8'h68);
        exec(frs_pkg::CMD_SCAN, 1'b0, 9'h037, 0, 0);
        results(8'h40, 8'h05, 8'h1f, 8'h68);
        exec(frs_pkg::CMD_READ, 1'b0, 9'h000, 0, frs_pkg::OVR_CYCLES - 1);
        results(8'h00, 8'h00, 8'h00, 8'h68);
        exec(frs_pkg::CMD_READ, 1'b0, 9'h000, 0, frs_pkg::OVR_CYCLES);
        results(8'h40, 8'h10, 8'h00, 8'h68);
        @(posedge clk);
        id_search <= 1'b1;
        exec(frs_pkg::CMD_READ_ID, 1'b0, 9'h000, 2, 0);
        results(8'h40, 8'h01, 8'h00, 8'h68);
        exec(frs_pkg::CMD_WRITE_DEL, 1'b0, 9'h020, 1, 0);
        results(8'h40, 8'h04, 8'h00, 8'h68);
        tally_and_finish();
    end
endmodule
`default_nettype wire
